// File: shared/spi_core_regs.svh
// Register offsets, field positions, reset values and counts of the serial core.
`ifndef SPI_CORE_REGS_SVH
`define SPI_CORE_REGS_SVH
`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_BAUD 8'h08
`define OFF_STAT 8'h0C
`define OFF_DATA 8'h10
`define IDX_CTRL1 3'h0
`define IDX_CTRL2 3'h1
`define IDX_BAUD 3'h2
`define IDX_STAT 3'h3
`define IDX_DATA 3'h4
`define IDX_NONE 3'h7
`define CTRL1_RST 8'h04
`define CTRL2_RST 8'h00
`define BAUD_RST 8'h00
`define DATA_RST 8'h00
`define CTRL2_MASK 8'h19
`define BAUD_MASK 8'h77
`define C1_RXIE 7
`define C1_EN 6
`define C1_TXIE 5
`define C1_MASTER_SELECT 4
`define C1_CPOL 3
`define C1_CLOCK_PHASE 2
`define C1_SELECT_OUTPUT_ENABLE 1
`define C1_LSBF 0
`define C2_FDE 4
`define C2_BIOE 3
`define C2_SW 0
`define ST_RF 7
`define ST_TEF 5
`define ST_MASTER_FAULT_FLAG 4
`define EDGE_LAST 4'hF
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define PIN_SCLK 0
`define PIN_MOSI 1
`define PIN_MISO 2
`define PIN_SS 3
`define PIN_RST 4'h8
`endif

// File: shared/spi_core_pkg.sv
// Types shared by the serial core files.
package spi_core_pkg;
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_LEAD = 2'b01,
      M_RUN = 2'b10,
      M_TAIL = 2'b11
   } mstate_t;
   typedef logic [7:0] byte_t;
   typedef logic [1:0] resp_t;
endpackage : spi_core_pkg

// File: design/spi_rate_tick.sv
// Half bit period tick generator for the master serial clock.
`timescale 1ns/100ps
module spi_rate_tick
   import spi_core_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run,
   input wire logic [2:0] prescale_select,
   input wire logic [2:0] rate_select,
   output logic tick
);
   logic [10:0] half;
   logic [10:0] cnt_r;
   logic tick_r;
   // Half period is prescale times half the rate divisor, never below one cycle.
   assign half = {7'h00, {1'b0, prescale_select} + 4'h1} << rate_select;
   assign tick = tick_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= 11'h000;
         tick_r <= 1'b0;
      end else if (ce) begin
         if (!run || cnt_r == half - 11'h001) begin
            cnt_r <= 11'h000;
         end else begin
            cnt_r <= cnt_r + 11'h001;
         end
         tick_r <= run && cnt_r == half - 11'h001;
      end
   end
endmodule : spi_rate_tick

// File: design/spi_buffered_transfer_core.sv
// Buffered serial peripheral core with status flags and an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "spi_core_regs.svh"
module spi_buffered_transfer_core
   import spi_core_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_n,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n,
   input wire logic ss_n_i,
   output logic ss_n_o,
   output logic ss_oe_n,
   output logic irq
);
   function automatic logic [2:0] reg_idx(input logic [7:0] a);
      case (a)
         `OFF_CTRL1: reg_idx = `IDX_CTRL1;
         `OFF_CTRL2: reg_idx = `IDX_CTRL2;
         `OFF_BAUD: reg_idx = `IDX_BAUD;
         `OFF_STAT: reg_idx = `IDX_STAT;
         `OFF_DATA: reg_idx = `IDX_DATA;
         default: reg_idx = `IDX_NONE;
      endcase
   endfunction : reg_idx

   byte_t c1_r, c2_r, br_r, rxb_r, txb_r, txs_r, rxs_r, wd_r, txs_nxt, stat, rd_mux;
   logic [7:0] awa_r;
   logic [3:0] s1_r, s2_r, s3_r, pf_r, ecnt_r;
   logic aw_held_r, w_held_r, ws_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [31:0] rdata_r;
   resp_t bresp_r, rresp_r;
   logic rf_r, txb_full_r, master_fault_flag_r, sh_full_r, rf_arm_r, tef_arm_r, master_fault_flag_arm_r, done_r;
   logic sclk_prev_r, sclk_r, out_r, sclk_oe_n_r, mosi_oe_n_r, miso_oe_n_r;
   logic ss_n_r, ss_oe_n_r, irq_r;
   mstate_t state_r;

   // Each pin passes three flops; a level is taken once the last two agree.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               s1_r[gi] <= 1'(`PIN_RST >> gi);
               s2_r[gi] <= 1'(`PIN_RST >> gi);
               s3_r[gi] <= 1'(`PIN_RST >> gi);
               pf_r[gi] <= 1'(`PIN_RST >> gi);
            end else if (ce) begin
               s1_r[gi] <= gi == `PIN_SCLK ? serial_clock_pin_i :
                  gi == `PIN_MOSI ? mosi_i : gi == `PIN_MISO ? miso_i : ss_n_i;
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  pf_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   wire en = c1_r[`C1_EN];
   wire master_select = c1_r[`C1_MASTER_SELECT];
   wire clock_phase = c1_r[`C1_CLOCK_PHASE];
   wire lsbf = c1_r[`C1_LSBF];
   wire sw = c2_r[`C2_SW];
   wire bioe = c2_r[`C2_BIOE];
   wire ss_f = pf_r[`PIN_SS];

   // Bus side decode.
   wire aw_hs = awvalid && awready_r;
   wire w_hs = wvalid && wready_r;
   wire ar_hs = arvalid && arready_r;
   wire do_wr = aw_held_r && w_held_r && !bvalid_r;
   wire [2:0] wr_idx = reg_idx(awa_r);
   wire [2:0] rd_idx = reg_idx(araddr);
   wire wr_c1_any = do_wr && wr_idx == `IDX_CTRL1;
   wire wr_c1 = wr_c1_any && ws_r;
   wire wr_c2 = do_wr && ws_r && wr_idx == `IDX_CTRL2;
   wire wr_br = do_wr && ws_r && wr_idx == `IDX_BAUD;
   wire wr_dat = do_wr && ws_r && wr_idx == `IDX_DATA;
   wire acc_dat = wr_dat && tef_arm_r && !txb_full_r;
   wire rd_st = ar_hs && rd_idx == `IDX_STAT;
   wire rd_dat = ar_hs && rd_idx == `IDX_DATA;

   assign stat = {rf_r, 1'b0, !txb_full_r, master_fault_flag_r, 4'h0};
   assign rd_mux = rd_idx == `IDX_CTRL1 ? c1_r : rd_idx == `IDX_CTRL2 ? c2_r :
      rd_idx == `IDX_BAUD ? br_r : rd_idx == `IDX_STAT ? stat :
      rd_idx == `IDX_DATA ? rxb_r : 8'h00;

   // Transfer engine terms.
   wire fault = en && master_select && c2_r[`C2_FDE] && !c1_r[`C1_SELECT_OUTPUT_ENABLE] && !ss_f;
   wire tick;
   wire m_run = en && master_select && state_r == M_RUN;
   wire s_edge = en && !master_select && !ss_f && pf_r[`PIN_SCLK] != sclk_prev_r;
   wire ev = m_run ? tick : s_edge;
   wire samp_e = ecnt_r[0] == clock_phase;
   wire shift_e = ev && !samp_e && ecnt_r != 4'h0;
   wire last = ev && ecnt_r == `EDGE_LAST;
   wire din = master_select ? (sw ? pf_r[`PIN_MOSI] : pf_r[`PIN_MISO]) :
      (sw ? pf_r[`PIN_MISO] : pf_r[`PIN_MOSI]);
   wire load = en && txb_full_r && (!sh_full_r || done_r);
   wire done_nxt = (master_select && state_r == M_TAIL && tick) || (!master_select && last);
   wire rf_clr = rd_dat && rf_arm_r;
   wire master_fault_flag_clr = wr_c1_any && master_fault_flag_arm_r;

   assign txs_nxt = load ? txb_r : !shift_e ? txs_r :
      lsbf ? txs_r >> 1 : txs_r << 1;
   wire out_nxt = lsbf ? txs_nxt[0] : txs_nxt[7];

   spi_rate_tick u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .run(state_r != M_IDLE),
      .prescale_select(br_r[6:4]),
      .rate_select(br_r[2:0]),
      .tick(tick)
   );

   // Register slave: address and data are taken in either order, answered together.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         awa_r <= 8'h00;
         wd_r <= 8'h00;
         ws_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         rresp_r <= `RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else if (ce) begin
         if (aw_hs) begin
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
            awa_r <= awaddr;
         end
         if (w_hs) begin
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
            wd_r <= wdata[7:0];
            ws_r <= wstrb[0];
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_idx == `IDX_NONE ? `RESP_DECERR : `RESP_OKAY;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
         if (ar_hs) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_mux};
            rresp_r <= rd_idx == `IDX_NONE ? `RESP_DECERR : `RESP_OKAY;
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // Control registers; status has no write path at all.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         c1_r <= `CTRL1_RST;
         c2_r <= `CTRL2_RST;
         br_r <= `BAUD_RST;
      end else if (ce) begin
         if (wr_c1) begin
            c1_r <= wd_r;
         end
         if (fault) begin
            c1_r[`C1_MASTER_SELECT] <= 1'b0;
         end
         if (wr_c2) begin
            c2_r <= wd_r & `CTRL2_MASK;
         end
         if (wr_br) begin
            br_r <= wd_r & `BAUD_MASK;
         end
      end
   end

   // Flags, buffers and their clearing sequences; a set beats a clear in the same cycle, except tef_arm_r, where an accepted data write wins.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rf_r <= 1'b0;
         master_fault_flag_r <= 1'b0;
         txb_full_r <= 1'b0;
         sh_full_r <= 1'b0;
         rf_arm_r <= 1'b0;
         tef_arm_r <= 1'b0;
         master_fault_flag_arm_r <= 1'b0;
         rxb_r <= `DATA_RST;
         txb_r <= `DATA_RST;
         irq_r <= 1'b0;
      end else if (ce) begin
         rf_r <= done_r || (rf_r && !rf_clr);
         // An armed data read (status read first) in the cycle a transfer ends frees the buffer for the new byte.
         if (done_r && (!rf_r || rf_clr)) begin
            rxb_r <= rxs_r;
         end
         master_fault_flag_r <= fault || (master_fault_flag_r && !master_fault_flag_clr);
         if (rd_st) begin
            rf_arm_r <= rf_r;
            tef_arm_r <= !txb_full_r && !acc_dat;
            master_fault_flag_arm_r <= master_fault_flag_r;
         end else begin
            if (rd_dat) begin
               rf_arm_r <= 1'b0;
            end
            if (acc_dat) begin
               tef_arm_r <= 1'b0;
            end
            if (wr_c1_any) begin
               master_fault_flag_arm_r <= 1'b0;
            end
         end
         if (acc_dat) begin
            txb_full_r <= 1'b1;
            txb_r <= wd_r;
         end else if (load) begin
            txb_full_r <= 1'b0;
         end
         if (load) begin
            sh_full_r <= 1'b1;
         end else if (done_r || !en) begin
            sh_full_r <= 1'b0;
         end
         irq_r <= (!txb_full_r && c1_r[`C1_TXIE]) ||
            ((rf_r || master_fault_flag_r) && c1_r[`C1_RXIE]);
      end
   end

   // Shifter and master sequence: select low, eight clock cycles, half a cycle of tail.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= M_IDLE;
         ecnt_r <= 4'h0;
         done_r <= 1'b0;
         txs_r <= 8'h00;
         rxs_r <= 8'h00;
         out_r <= 1'b0;
         sclk_r <= 1'b0;
         sclk_prev_r <= 1'b0;
      end else if (ce) begin
         sclk_prev_r <= pf_r[`PIN_SCLK];
         done_r <= done_nxt;
         txs_r <= txs_nxt;
         out_r <= out_nxt;
         if (ev && samp_e) begin
            rxs_r <= lsbf ? {din, rxs_r[7:1]} : {rxs_r[6:0], din};
         end
         if (ev) begin
            ecnt_r <= ecnt_r + 4'h1;
         end
         if (!master_select && ss_f) begin
            ecnt_r <= 4'h0;
         end
         if (fault || !en || !master_select) begin
            state_r <= M_IDLE;
            sclk_r <= c1_r[`C1_CPOL];
         end else begin
            case (state_r)
               M_IDLE: begin
                  sclk_r <= c1_r[`C1_CPOL];
                  ecnt_r <= 4'h0;
                  if (sh_full_r && !done_r) begin
                     state_r <= M_LEAD;
                  end
               end
               M_LEAD: begin
                  if (tick) begin
                     state_r <= M_RUN;
                  end
               end
               M_RUN: begin
                  if (tick) begin
                     sclk_r <= !sclk_r;
                  end
                  if (last) begin
                     state_r <= M_TAIL;
                  end
               end
               M_TAIL: begin
                  if (tick) begin
                     state_r <= M_IDLE;
                  end
               end
               default: begin
                  state_r <= M_IDLE;
               end
            endcase
         end
      end
   end

   // Pin drivers; enables are active low.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_oe_n_r <= 1'b1;
         mosi_oe_n_r <= 1'b1;
         miso_oe_n_r <= 1'b1;
         ss_n_r <= 1'b1;
         ss_oe_n_r <= 1'b1;
      end else if (ce) begin
         sclk_oe_n_r <= !(en && master_select && !fault);
         mosi_oe_n_r <= !(en && master_select && !fault && (!sw || bioe));
         miso_oe_n_r <= !(en && !master_select && !ss_f && (!sw || bioe) && !(master_fault_flag_r && !sw));
         ss_n_r <= !(en && master_select && state_r != M_IDLE);
         ss_oe_n_r <= !(en && master_select && !fault && c2_r[`C2_FDE] && c1_r[`C1_SELECT_OUTPUT_ENABLE]);
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign serial_clock_pin_o = sclk_r;
   assign serial_clock_pin_oe_n = sclk_oe_n_r;
   assign mosi_o = out_r;
   assign mosi_oe_n = mosi_oe_n_r;
   assign miso_o = out_r;
   assign miso_oe_n = miso_oe_n_r;
   assign ss_n_o = ss_n_r;
   assign ss_oe_n = ss_oe_n_r;
   assign irq = irq_r;

   // Checks; they pause with the clock enable because all state freezes then.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst || !ce);

   logic rd_st_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_st_r <= 1'b0;
      end else if (ce && ar_hs) begin
         rd_st_r <= rd_idx == `IDX_STAT;
      end
   end

   sequence s_queued_end;
      done_r && txb_full_r && en;
   endsequence
   sequence s_reloaded;
      sh_full_r && !txb_full_r;
   endsequence

   a_status_zero_bits:
      assert property (rvalid_r && rd_st_r |-> rdata_r[6] == 1'b0 && rdata_r[3:0] == 4'h0)
      else $error("status reserved bits not zero");
   a_rx_full_set:
      assert property (done_r |=> rf_r && (rxb_r == $past(rxs_r) || $past(rf_r && !rf_clr)))
      else $error("receive-full not set after transfer");
   a_rx_full_clear:
      assert property ($fell(rf_r) |-> $past(rd_dat) && $past(rf_arm_r))
      else $error("receive-full cleared without sequence");
   a_tx_write_ignored:
      assert property (wr_dat && !tef_arm_r && !txb_full_r |=> !txb_full_r)
      else $error("unarmed data write accepted");
   a_irq_tx_empty:
      assert property (!txb_full_r && c1_r[`C1_TXIE] |=> irq_r)
      else $error("transmit interrupt missing");
   a_idle_quick_load:
      assert property (en && txb_full_r && !sh_full_r |-> ##[1:2] !txb_full_r)
      else $error("idle load too slow");
   a_queued_reload:
      assert property (s_queued_end |=> s_reloaded)
      else $error("queued byte not reloaded");
   a_fault_cause:
      assert property ($rose(master_fault_flag_r) |-> $past(fault))
      else $error("mode fault without cause");
   a_fault_drops_master:
      assert property ($rose(master_fault_flag_r) |-> !master_select && state_r == M_IDLE)
      else $error("master kept after fault");
   a_overrun_keeps:
      assert property (done_r && rf_r && !rf_clr |=> $stable(rxb_r))
      else $error("receive buffer overwritten");
endmodule : spi_buffered_transfer_core

// File: verif/spi_peer_model.sv
// Behavioural external serial slave, clock phase 0 and polarity 0, facing the core.
`timescale 1ns/100ps
module spi_peer_model
   import spi_core_pkg::*;
(
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic lsb_first,
   input wire byte_t tx_seed,
   output logic miso,
   output byte_t rx_byte,
   output logic [7:0] frames
);
   byte_t sh;
   byte_t acc;
   int n;
   initial begin
      miso = 1'b0;
      rx_byte = 8'h00;
      frames = 8'h00;
      acc = 8'h00;
      n = 0;
   end
   // The reply moves on with every frame, so a lost or repeated byte shows up.
   always @(negedge ss_n) begin
      sh = tx_seed + frames;
      n = 0;
      miso = lsb_first ? sh[0] : sh[7];
   end
   always @(posedge sclk) begin
      if (!ss_n) begin
         acc = lsb_first ? {mosi, acc[7:1]} : {acc[6:0], mosi};
         n = n + 1;
      end
   end
   always @(negedge sclk) begin
      if (!ss_n && n < 8) begin
         sh = lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
         miso = lsb_first ? sh[0] : sh[7];
      end
   end
   // A released line shows the inverse of its last bit, never a friendly stale value.
   always @(posedge ss_n) begin
      if (n == 8) begin
         rx_byte = acc;
         frames = frames + 8'h01;
      end
      miso = ~miso;
   end
endmodule : spi_peer_model

// File: verif/tb.sv
// Self-checking bench for the buffered serial core with a behavioural serial slave.
`timescale 1ns/100ps
`include "spi_core_regs.svh"
module tb
   import spi_core_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst, ce, awvalid, wvalid, bready, arvalid, rready, tb_ss_n, peer_lsb;
   logic [7:0] awaddr, araddr, frames;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, irq;
   resp_t bresp, rresp;
   logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_oe_n;
   logic sclk_hold, mosi_hold, peer_miso;
   logic ext_drv, tb_sclk, tb_mosi;
   byte_t peer_seed, peer_rx;
   byte_t s0, d0, got;
   wire sclk_w, mosi_w, miso_w, ss_w;
   logic [63:0] rq[$];
   logic [63:0] bq[$];
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 25;
   int i;
   always #5 ref_clk = ~ref_clk;
   assign sclk_w = sclk_oe_n ? (ext_drv ? tb_sclk : ~sclk_hold) : sclk_o;
   assign mosi_w = mosi_oe_n ? (ext_drv ? tb_mosi : ~mosi_hold) : mosi_o;
   assign miso_w = miso_oe_n ? peer_miso : miso_o;
   assign ss_w = ss_oe_n ? tb_ss_n : ss_n_o;
   always @(posedge ref_clk) begin
      if (!sclk_oe_n) sclk_hold <= sclk_o;
      if (!mosi_oe_n) mosi_hold <= mosi_o;
   end
   spi_buffered_transfer_core i_dut (
      .ref_clk, .rst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk_o),
      .serial_clock_pin_oe_n(sclk_oe_n), .mosi_i(mosi_w), .mosi_o, .mosi_oe_n,
      .miso_i(miso_w), .miso_o, .miso_oe_n, .ss_n_i(ss_w), .ss_n_o, .ss_oe_n, .irq
   );
   spi_peer_model i_peer (
      .sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .lsb_first(peer_lsb), .tx_seed(peer_seed),
      .miso(peer_miso), .rx_byte(peer_rx), .frames(frames)
   );
   task automatic conclude;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(inout int t);
      @(posedge ref_clk);
      t++;
      if (t > 3000) begin
         error_cnt++;
         $display("ERROR t=%0t wait bound used up got=%h exp=%h", $time, t, 0);
         conclude();
      end
   endtask : tick
   // Every read answer is compared against the oldest note, in issue order.
   always @(posedge ref_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) cmp({30'h0, rresp, rdata}, rq.pop_front());
      if (bvalid === 1'b1 && bready === 1'b1) cmp({62'h0, bresp}, bq.pop_front());
   end
   task automatic axw(input logic [7:0] a, input byte_t d, input resp_t r);
      int t;
      logic aw_ok, w_ok;
      bq.push_back({62'h0, r});
      aw_ok = 1'b0;
      w_ok = 1'b0;
      t = 0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         tick(t);
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok));
      bready <= 1'b1;
      while (bvalid !== 1'b1) tick(t);
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a, input byte_t d, input resp_t r);
      int t;
      rq.push_back({30'h0, r, 24'h0, d});
      t = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do tick(t); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      while (rvalid !== 1'b1) tick(t);
      rready <= 1'b0;
   endtask : axr
   task automatic lvl(input logic v, output int t);
      t = 0;
      while (!(sclk_w === v && ss_w === 1'b0)) tick(t);
   endtask : lvl
   task automatic wait_frames(input logic [7:0] n);
      int t;
      t = 0;
      while (frames !== n) tick(t);
   endtask : wait_frames
   // Two bytes back to back; the second received byte must be dropped unread.
   task automatic master_pair(input logic lsb);
      byte_t m0, m1, ps, p0;
      logic [7:0] f;
      int t;
      m0 = 8'($random(seed));
      m1 = 8'($random(seed));
      ps = 8'($random(seed));
      f = frames;
      p0 = ps + f;
      peer_seed <= ps;
      peer_lsb <= lsb;
      axw(`OFF_CTRL1, {7'h29, lsb}, `RESP_OKAY);
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
      axw(`OFF_DATA, m0, `RESP_OKAY);
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
      axw(`OFF_DATA, m1, `RESP_OKAY);
      lvl(1'b1, t);
      lvl(1'b0, t);
      lvl(1'b1, t);
      cmp(t, 16);
      wait_frames(f + 8'h01);
      cmp(peer_rx, m0);
      wait_frames(f + 8'h02);
      cmp(peer_rx, m1);
      repeat (4) @(posedge ref_clk);
      axr(`OFF_STAT, 8'hA0, `RESP_OKAY);
      axr(`OFF_DATA, p0, `RESP_OKAY);
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
   endtask : master_pair
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, peer_lsb, ext_drv, tb_sclk, tb_mosi} = 9'h000;
      tb_ss_n = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      peer_seed = 8'h00;
      sclk_hold = 1'b0;
      mosi_hold = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      axr(`OFF_CTRL1, `CTRL1_RST, `RESP_OKAY);
      axr(`OFF_DATA, `DATA_RST, `RESP_OKAY);
      axr(8'h14, 8'h00, `RESP_DECERR);
      axw(8'h18, 8'h5A, `RESP_DECERR);
      axw(`OFF_CTRL2, 8'h10, `RESP_OKAY);
      axw(`OFF_BAUD, 8'h13, `RESP_OKAY);
      axw(`OFF_CTRL1, 8'h52, `RESP_OKAY);
      axw(`OFF_DATA, 8'h3C, `RESP_OKAY);
      repeat (60) @(posedge ref_clk);
      cmp({frames, ss_w}, 9'h001);
      axw(`OFF_STAT, 8'hFF, `RESP_OKAY);
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
      for (i = 0; i < 2; i++) master_pair(i[0]);
      // Another master pulls select low while this one has no select output.
      axw(`OFF_CTRL1, 8'h50, `RESP_OKAY);
      tb_ss_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      cmp({sclk_oe_n, mosi_oe_n}, 2'b11);
      axr(`OFF_CTRL1, 8'h40, `RESP_OKAY);
      axw(`OFF_CTRL1, 8'hC0, `RESP_OKAY);
      repeat (4) @(posedge ref_clk);
      cmp(irq, 1);
      tb_ss_n <= 1'b1;
      axr(`OFF_STAT, 8'h30, `RESP_OKAY);
      axw(`OFF_CTRL1, 8'h60, `RESP_OKAY);
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
      repeat (4) @(posedge ref_clk);
      cmp(irq, 1);
      axw(`OFF_CTRL1, 8'h40, `RESP_OKAY);
      repeat (4) @(posedge ref_clk);
      cmp(irq, 0);
      // An outside master runs one phase 0 slave transfer; its clock settles before select.
      ext_drv <= 1'b1;
      s0 = 8'($random(seed));
      d0 = 8'($random(seed));
      axr(`OFF_STAT, 8'h20, `RESP_OKAY);
      axw(`OFF_DATA, s0, `RESP_OKAY);
      tb_ss_n <= 1'b0;
      for (i = 7; i >= 0; i--) begin
         tb_mosi <= d0[i];
         repeat (8) @(posedge ref_clk);
         got[i] = miso_w;
         tb_sclk <= 1'b1;
         repeat (8) @(posedge ref_clk);
         tb_sclk <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      tb_ss_n <= 1'b1;
      cmp(got, s0);
      axr(`OFF_STAT, 8'hA0, `RESP_OKAY);
      axr(`OFF_DATA, d0, `RESP_OKAY);
      conclude();
   end
endmodule : tb
